// *** nsx_pkg.sv ***
// package: opcode encodings, field positions, widths and reset values for the decoder and executor
package nsx_pkg;
  // widths
  localparam int unsigned OPW   = 14;
  localparam int unsigned DW    = 8;
  localparam int unsigned AW    = 7;
  // field positions
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned ADDR_LSB = 0;
  // opcode patterns
  localparam logic [5:0] SWAP_PAT  = 6'h0E;   // 00 1110
  localparam logic [5:0] RXOR_PAT  = 6'h06;   // 00 0110
  localparam logic [5:0] LXOR_PAT  = 6'h3A;   // 11 1010
  localparam logic [10:0] PDIR_PAT = 11'h00C; // 00 0000 0110 0
  // port selector range for the legacy direction load
  localparam logic [2:0] PSEL_MIN  = 3'h5;
  localparam logic [2:0] PSEL_MAX  = 3'h7;
  // addresses at which the direction registers also sit in the file map
  localparam logic [6:0] DIR_ADDR_BASE = 7'h05;
  localparam int unsigned NDIR     = 3;
  // reset values
  localparam logic [7:0] W_RST     = 8'h00;
  localparam logic [7:0] DIR_RST   = 8'hFF;
  // decoded operation
  typedef enum logic [2:0] {
    NSX_OP_NONE, NSX_OP_SWAP, NSX_OP_LXOR, NSX_OP_RXOR, NSX_OP_PDIR
  } nsx_op_e;
endpackage

// *** nsx_decode.sv ***
// opcode decoder: classifies a 14-bit word into one of the four handled operations, or NSX_OP_NONE if none matches
`timescale 1ns/1ps
module nsx_decode (
  // opcode in
  input  wire logic [13:0]       opcode,
  // decoded op out
  output nsx_pkg::nsx_op_e       op
);
  // combinational classification
  always_comb begin
    op = nsx_pkg::NSX_OP_NONE;
    if (opcode[13:8] == nsx_pkg::SWAP_PAT) begin
      op = nsx_pkg::NSX_OP_SWAP;
    end else if (opcode[13:8] == nsx_pkg::LXOR_PAT) begin
      op = nsx_pkg::NSX_OP_LXOR;
    end else if (opcode[13:8] == nsx_pkg::RXOR_PAT) begin
      op = nsx_pkg::NSX_OP_RXOR;
    end else if (opcode[13:3] == nsx_pkg::PDIR_PAT && opcode[2:0] >= nsx_pkg::PSEL_MIN
                 && opcode[2:0] <= nsx_pkg::PSEL_MAX) begin
      op = nsx_pkg::NSX_OP_PDIR;
    end
  end
endmodule

// *** nsx_exec.sv ***
// execute unit for nibble swap, literal xor, register xor and port direction load
`timescale 1ns/1ps
// Summary of operation
// - swap puts f low nibble high
// - swap result to w or f, no flags
// - literal xor combines w with literal
// - literal xor writes w, updates zero flag
// - direction load copies w for ports 5-7
// - direction registers reachable as file registers
// - register xor combines w with file register
// - register xor result to w or f, zero flag
module nsx_exec (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // instruction fetch side
  input  wire logic        instr_valid,   // opcode present this cycle
  input  wire logic [13:0] opcode,
  // file register read port (combinational, addressed by file_addr)
  output logic      [6:0]  file_addr,
  input  wire logic [7:0]  file_rdata,
  // file register write port
  output logic             file_we,
  output logic      [6:0]  file_waddr,
  output logic      [7:0]  file_wdata,
  // generic data-move access to direction registers
  input  wire logic        mov_we,
  input  wire logic [6:0]  mov_addr,
  input  wire logic [7:0]  mov_wdata,
  output logic      [7:0]  dir_rdata,     // read data for mov_addr
  // architectural state out
  output logic      [7:0]  w_out,
  output logic             zero_we,       // pulse: zero flag updated
  output logic             zero_out,      // new zero flag value
  output logic      [7:0]  dir_out [3]    // direction registers, ports 5..7
);
  // all state
  typedef struct packed {
    logic [7:0]      w;
    logic [2:0][7:0] dir;
    logic            fwe;
    logic [6:0]      fwa;
    logic [7:0]      fwd;
    logic            zwe;
    logic            z;
  } nsx_state_s;

  nsx_state_s st_reg;   // registered state
  nsx_state_s st_next;  // next state
  nsx_pkg::nsx_op_e op; // decoded operation
  logic [7:0] swapped;  // nibble-swapped file value
  logic [7:0] lx_res;   // literal xor result
  logic [7:0] rx_res;   // register xor result
  logic       dsel;     // destination bit
  logic [7:0] f_val;    // file operand, pending write forwarded

  // direction register index for a file address, or NDIR if not one
  function automatic logic [1:0] dir_index(input logic [6:0] a);
    logic [6:0] d;
    d = a - nsx_pkg::DIR_ADDR_BASE;
    if (a >= nsx_pkg::DIR_ADDR_BASE && d < 7'(nsx_pkg::NDIR)) begin
      dir_index = d[1:0];
    end else begin
      dir_index = 2'h3;
    end
  endfunction

  // decoder instance
  nsx_decode u_dec (
    .opcode (opcode),
    .op     (op)
  );

  // datapath
  assign file_addr = opcode[6:0];
  assign dsel      = opcode[nsx_pkg::DEST_BIT];
  // the file write port is registered, so a write lands one edge late; an
  // operand read of that same address in the next cycle takes the pending value
  assign f_val     = (st_reg.fwe && st_reg.fwa == file_addr) ? st_reg.fwd : file_rdata;
  assign swapped   = {f_val[3:0], f_val[7:4]};
  assign lx_res    = st_reg.w ^ opcode[7:0];
  assign rx_res    = st_reg.w ^ f_val;

  // next-state computation, single cycle per instruction
  always_comb begin
    logic [1:0] mi;
    mi = dir_index(mov_addr);
    st_next     = st_reg;
    st_next.fwe = 1'b0;
    st_next.zwe = 1'b0;
    // ordinary data-move access
    if (mov_we && mi != 2'h3) begin
      st_next.dir[mi] = mov_wdata;
    end
    if (instr_valid) begin
      case (op)
        nsx_pkg::NSX_OP_SWAP: begin
          // no flag update for swap
          if (dsel) begin
            st_next.fwe = 1'b1;
            st_next.fwa = file_addr;
            st_next.fwd = swapped;
          end else begin
            st_next.w = swapped;
          end
        end
        nsx_pkg::NSX_OP_LXOR: begin
          st_next.w   = lx_res;
          st_next.zwe = 1'b1;
          st_next.z   = (lx_res == 8'h00);
        end
        nsx_pkg::NSX_OP_RXOR: begin
          if (dsel) begin
            st_next.fwe = 1'b1;
            st_next.fwa = file_addr;
            st_next.fwd = rx_res;
          end else begin
            st_next.w = rx_res;
          end
          st_next.zwe = 1'b1;
          st_next.z   = (rx_res == 8'h00);
        end
        nsx_pkg::NSX_OP_PDIR: begin
          // instruction wins over a simultaneous data move
          st_next.dir[opcode[2:0] - nsx_pkg::PSEL_MIN] = st_reg.w;
        end
        default: begin
          // other instructions are handled elsewhere
        end
      endcase
    end
  end

  // state register, one edge per instruction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{w: nsx_pkg::W_RST,
                  dir: {3{nsx_pkg::DIR_RST}},
                  fwe: 1'b0, fwa: 7'h00, fwd: 8'h00, zwe: 1'b0, z: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign w_out      = st_reg.w;
  assign file_we    = st_reg.fwe;
  assign file_waddr = st_reg.fwa;
  assign file_wdata = st_reg.fwd;
  assign zero_we    = st_reg.zwe;
  assign zero_out   = st_reg.z;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_dir
      assign dir_out[g] = st_reg.dir[g];
    end
  endgenerate
  // read back of direction registers through ordinary access
  always_comb begin
    logic [1:0] ri;
    ri = dir_index(mov_addr);
    dir_rdata = (ri == 2'h3) ? 8'h00 : st_reg.dir[ri];
  end

  // checks
  chk_swap_nibbles: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && op == nsx_pkg::NSX_OP_SWAP && !dsel
    |=> w_out == {$past(f_val[3:0]), $past(f_val[7:4])})
    else $error("swap to w wrong");
  chk_swap_noflag: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && op == nsx_pkg::NSX_OP_SWAP |=> !zero_we)
    else $error("swap touched zero flag");
  chk_swap_tofile: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && op == nsx_pkg::NSX_OP_SWAP && dsel
    |=> file_we && $stable(w_out) && file_wdata == {$past(f_val[3:0]), $past(f_val[7:4])})
    else $error("swap to file wrong");
  chk_lxor_value: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && op == nsx_pkg::NSX_OP_LXOR |=> w_out == ($past(w_out) ^ $past(opcode[7:0])))
    else $error("literal xor wrong");
  chk_lxor_zero: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && op == nsx_pkg::NSX_OP_LXOR |=> zero_we && zero_out == (w_out == 8'h00))
    else $error("literal xor zero flag wrong");
  chk_pdir_load: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && opcode == 14'h0065 |=> dir_out[0] == $past(w_out) && !zero_we)
    else $error("direction load wrong");
  chk_dir_move: assert property (@(posedge clk) disable iff (!reset_n)
    mov_we && mov_addr == 7'h07 && !(instr_valid && op == nsx_pkg::NSX_OP_PDIR)
    |=> dir_out[2] == $past(mov_wdata))
    else $error("direction move wrong");
  chk_rxor_value: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && op == nsx_pkg::NSX_OP_RXOR && !dsel
    |=> w_out == ($past(w_out) ^ $past(f_val)))
    else $error("register xor wrong");
  chk_rxor_dest: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && op == nsx_pkg::NSX_OP_RXOR && dsel
    |=> file_we && zero_we && zero_out == (file_wdata == 8'h00) && $stable(w_out))
    else $error("register xor to file wrong");
  chk_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
    !instr_valid && !mov_we |=> !file_we && !zero_we && $stable(w_out))
    else $error("activity without instruction");
  chk_lxor_nofile: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && op == nsx_pkg::NSX_OP_LXOR |=> !file_we)
    else $error("literal xor wrote the file");
  chk_rxor_file_value: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && op == nsx_pkg::NSX_OP_RXOR && dsel
    |=> file_waddr == $past(file_addr) && file_wdata == ($past(w_out) ^ $past(f_val)))
    else $error("register xor file write wrong");
  chk_pdir_wins: assert property (@(posedge clk) disable iff (!reset_n)
    instr_valid && opcode == 14'h0067 && mov_we && mov_addr == 7'h07
    |=> dir_out[2] == $past(w_out))
    else $error("direction load lost to data move");
  chk_dir_read: assert property (@(posedge clk) disable iff (!reset_n)
    mov_addr == 7'h06 |-> dir_rdata == dir_out[1])
    else $error("direction read back wrong");
  chk_operand_bypass: assert property (@(posedge clk) disable iff (!reset_n)
    file_we && file_waddr == file_addr |-> f_val == file_wdata)
    else $error("pending file write not forwarded");
  // main scenarios for coverage
  cov_operand_bypass: cover property (@(posedge clk)
    instr_valid && file_we && file_waddr == file_addr);
  cov_swap: cover property (@(posedge clk) instr_valid && op == nsx_pkg::NSX_OP_SWAP);
  cov_lxor_zero: cover property (@(posedge clk) zero_we && zero_out);
  cov_rxor_file: cover property (@(posedge clk) instr_valid && op == nsx_pkg::NSX_OP_RXOR && dsel);
  cov_pdir: cover property (@(posedge clk) instr_valid && op == nsx_pkg::NSX_OP_PDIR);
endmodule

// *** nsx_regfile.sv ***
// register file model standing behind the executor's file ports
`timescale 1ns/1ps
module nsx_regfile (
  // clock
  input  wire logic       clk,
  // read port
  input  wire logic [6:0] file_addr,
  output logic      [7:0] file_rdata,
  // write port
  input  wire logic       file_we,
  input  wire logic [6:0] file_waddr,
  input  wire logic [7:0] file_wdata
);
  logic [7:0] mem [128]; // storage, preset to a known pattern
  // preset contents so reads are never unknown
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 29) ^ 8'hA5;
    end
  end
  // read data answers in the same cycle
  assign file_rdata = mem[file_addr];
  // write lands on the edge that ends the write pulse
  always @(posedge clk) begin
    if (file_we) begin
      mem[file_waddr] <= file_wdata;
    end
  end
endmodule

// *** test_nibble_swap_xor_dirload_exec.sv ***
// self-checking bench for the swap, xor and direction load executor
`timescale 1ns/1ps
module test_nibble_swap_xor_dirload_exec;
  logic        clk, reset_n, instr_valid, file_we, mov_we, zero_we, zero_out;
  logic [13:0] opcode;
  logic [6:0]  file_addr, file_waddr, mov_addr, a, pa;
  logic [7:0]  file_rdata, file_wdata, mov_wdata, dir_rdata, w_out;
  logic [7:0]  dir_out [3];   // direction registers seen
  logic [7:0]  dir_s [3];     // shadow direction registers
  logic [7:0]  w_s, f, r, k, pd; // shadow working register, scratch, pending write data
  logic [2:0]  s;
  logic        d, seen, pw;
  logic [49:0] exp_q [$];     // expected results, oldest first
  logic [49:0] obs;           // packed outputs seen
  int          miscompares, checked;
  nsx_exec u_nsx_exec (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .opcode(opcode), .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .mov_we(mov_we), .mov_addr(mov_addr),
    .mov_wdata(mov_wdata), .dir_rdata(dir_rdata), .w_out(w_out), .zero_we(zero_we),
    .zero_out(zero_out), .dir_out(dir_out));
  nsx_regfile u_nsx_regfile (.clk(clk), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata));
  // packs one cycle's visible state, masking fields that carry no meaning
  function automatic logic [49:0] pack(logic [7:0] w, logic fw, logic [6:0] fa,
      logic [7:0] fd, logic zw, logic z, logic [7:0] dv [3]);
    return {w, fw, fw ? {fa, fd} : 15'h0000, zw, zw & z, dv[0], dv[1], dv[2]};
  endfunction
  // compares and counts
  task automatic check(string name, logic [49:0] e, logic [49:0] o);
    checked++;
    if (o !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, e, o);
    end
  endtask
  // drives one instruction and notes what must follow it
  task automatic issue(logic [13:0] op, logic fw, logic zw, logic mv = 1'b0);
    instr_valid = 1'b1;
    mov_we = mv;
    opcode = op;
    {pw, pa, pd} = {fw, a, r}; // file write still pending when the next operand is read
    exp_q.push_back(pack(w_s, fw, a, r, zw, r == 8'h00, dir_s));
  endtask
  // prints counts and verdict, then ends the run
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // clock
  always #10 clk = ~clk;
  // remembers whether an instruction was taken at this edge
  always @(posedge clk) seen <= instr_valid;
  // one cycle after each taken instruction the oldest note is compared
  always @(negedge clk) begin
    if (seen && reset_n) begin
      obs = pack(w_out, file_we, file_waddr, file_wdata, zero_we, zero_out, dir_out);
      check("result", exp_q.pop_front(), obs);
    end
  end
  // watchdog
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
  // main sequence
  initial begin
    {clk, instr_valid, opcode, mov_we, mov_addr, mov_wdata, reset_n, pw} = '0;
    pa = 7'h08;
    w_s = nsx_pkg::W_RST;
    dir_s = '{3{nsx_pkg::DIR_RST}};
    void'($urandom(32'h69AA));
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    check("reset", pack(w_s, 1'b0, a, r, 1'b0, 1'b0, dir_s), pack(w_out, file_we,
      file_waddr, file_wdata, zero_we, zero_out, dir_out));
    repeat (300) begin
      @(negedge clk);
      s = 3'($urandom);
      a = (s == 3'h0) ? pa : 7'(8 + $urandom % 120); // now and then reuse the last address
      d = 1'($urandom);
      k = 8'($urandom);
      f = (pw && pa == a) ? pd : u_nsx_regfile.mem[a]; // a pending write lands at the next edge
      pw = 1'b0;
      case ($urandom % 6)
        0: begin
          r = {f[3:0], f[7:4]};
          if (!d) w_s = r;
          issue({nsx_pkg::SWAP_PAT, d, a}, d, 1'b0);
        end
        1: begin
          if (s < 3'h2) k = w_s; // forces a zero result now and then
          r = w_s ^ k;
          w_s = r;
          issue({nsx_pkg::LXOR_PAT, k}, 1'b0, 1'b1);
        end
        2: begin
          r = w_s ^ f;
          if (!d) w_s = r;
          issue({nsx_pkg::RXOR_PAT, d, a}, d, 1'b1);
        end
        3: begin
          if (s >= 3'h5) dir_s[s - 3'h5] = w_s;
          mov_addr = {4'h0, s};
          mov_wdata = ~w_s; // a colliding data move must lose to the load
          issue({nsx_pkg::PDIR_PAT, s}, 1'b0, 1'b0, s >= 3'h5);
        end
        4: issue(14'h0000, 1'b0, 1'b0);
        default: begin
          s = 3'(5 + s % 3);
          instr_valid = 1'b0;
          mov_we = 1'b1;
          mov_addr = {4'h0, s};
          mov_wdata = k;
          dir_s[s - 3'h5] = k;
          @(negedge clk);
          mov_we = 1'b0;
          check("dir_rdata", 50'(k), 50'(dir_rdata));
          mov_addr = a;
          #1 check("dir_rdata", 50'h0, 50'(dir_rdata));
        end
      endcase
    end
    @(negedge clk);
    instr_valid = 1'b0;
    mov_we = 1'b0;
    @(negedge clk);
    // second reset after the last instruction, just before the end of the run
    reset_n = 1'b0;
    w_s = nsx_pkg::W_RST;
    dir_s = '{3{nsx_pkg::DIR_RST}};
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    check("reset", pack(w_s, 1'b0, a, r, 1'b0, 1'b0, dir_s), pack(w_out, file_we,
      file_waddr, file_wdata, zero_we, zero_out, dir_out));
    @(negedge clk);
    finish_test();
  end
endmodule
